// ### design/rrs_pkg.sv
package rrs_pkg;
    // Register byte offsets on the AXI4-Lite port.
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACC = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0C;
    localparam logic [7:0] OFF_PUSH = 8'h10;
    localparam logic [7:0] OFF_FADDR = 8'h14;
    localparam logic [7:0] OFF_FDATA = 8'h18;
    localparam logic [7:0] OFF_WDOG = 8'h1C;

    // Status register field positions.
    localparam int ST_BUSY = 0;
    localparam int ST_C = 1;
    localparam int ST_HCARRY = 2;
    localparam int ST_Z = 3;
    localparam int ST_PWRDN = 4;
    localparam int ST_EXPIRY = 5;
    localparam int ST_SLEEP = 6;
    localparam int ST_ILL = 7;
    localparam int ST_SP = 8;

    // Opcode patterns: OPC_SLEEP is a whole 16-bit word, the others match its upper bits.
    localparam logic [15:0] OPC_SLEEP = 16'h0003;
    localparam logic [14:0] OPC_RETURN = 15'h0009;
    localparam logic [7:0] OPC_RET_LIT = 8'h0C;
    localparam logic [7:0] OPC_LIT_SUB = 8'h08;
    localparam logic [5:0] OPC_ROT_LEFT = 6'h0D;
    localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;

    // Reset values.
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;

    localparam int STACK_DEPTH = 16;
    localparam int FILE_DEPTH = 128;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_RUN = 2'b01,
        EX_SECOND = 2'b10
    } rrs_state_t;

    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic power_down_flag_n;
        logic watchdog_expiry_flag_n;
    } rrs_flags_t;

    localparam rrs_flags_t FLAGS_RST = 5'b00011;
endpackage

// ### design/rrs_exec.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rrs_exec
    import rrs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Core side.
    output logic sleep_out,
    output logic wdog_clear_out
);

    // Bus slave state.
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    // Core state.
    rrs_state_t state_q, state_d;
    logic [15:0] op_q, op_d;
    logic [7:0] acc_q, acc_d;
    logic [14:0] pc_q, pc_d;
    rrs_flags_t flags_q, flags_d;
    logic [14:0] stack_q [STACK_DEPTH], stack_d [STACK_DEPTH];
    logic [3:0] sp_q, sp_d;
    logic [7:0] file_q [FILE_DEPTH], file_d [FILE_DEPTH];
    logic [6:0] faddr_q, faddr_d;
    logic [7:0] wdog_q, wdog_d, presc_q, presc_d;
    logic asleep_q, asleep_d, illegal_q, illegal_d, wclr_q, wclr_d;
    logic [31:0] status_rd;
    logic [14:0] top_entry;
    logic [7:0] k_lit, operand, rot;
    logic [8:0] diff;
    logic set_ill;
    always_comb begin
        status_rd = 32'h0000_0000;
        status_rd[ST_BUSY] = (state_q != EX_IDLE);
        status_rd[ST_C] = flags_q.carry;
        status_rd[ST_HCARRY] = flags_q.half_carry_flag;
        status_rd[ST_Z] = flags_q.zero;
        status_rd[ST_PWRDN] = flags_q.power_down_flag_n;
        status_rd[ST_EXPIRY] = flags_q.watchdog_expiry_flag_n;
        status_rd[ST_SLEEP] = asleep_q;
        status_rd[ST_ILL] = illegal_q;
        status_rd[ST_SP +: 4] = sp_q;
        top_entry = stack_q[sp_q - 4'h1];
        k_lit = op_q[7:0];
        operand = file_q[op_q[6:0]];
        diff = {1'b0, k_lit} - {1'b0, acc_q};
    end

    always_comb begin
        awready_d = awready_q;
        wready_d = wready_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        awaddr_d = awaddr_q;
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        state_d = state_q;
        op_d = op_q;
        acc_d = acc_q;
        pc_d = pc_q;
        flags_d = flags_q;
        stack_d = stack_q;
        sp_d = sp_q;
        file_d = file_q;
        faddr_d = faddr_q;
        asleep_d = asleep_q;
        illegal_d = illegal_q;
        wclr_d = 1'b0;
        set_ill = 1'b0;
        rot = 8'h00;
        // The watchdog runs freely: prescaler every cycle, counter on prescaler wrap.
        presc_d = presc_q + 8'h01;
        wdog_d = (presc_q == 8'hFF) ? wdog_q + 8'h01 : wdog_q;

        // Execution.
        case (state_q)
            EX_IDLE: begin
            end
            EX_RUN: begin
                state_d = EX_IDLE;
                pc_d = pc_q + 15'h0001;
                if (op_q[15:8] == OPC_RET_LIT) begin
                    acc_d = k_lit;
                    pc_d = top_entry;
                    sp_d = sp_q - 4'h1;
                    state_d = EX_SECOND;
                end else if (op_q[15:1] == OPC_RETURN) begin
                    pc_d = top_entry;
                    sp_d = sp_q - 4'h1;
                    state_d = EX_SECOND;
                end else if (op_q[15:10] == OPC_ROT_LEFT || op_q[15:10] == OPC_ROT_RIGHT) begin
                    if (op_q[15:10] == OPC_ROT_LEFT) begin
                        rot = {operand[6:0], flags_q.carry};
                        flags_d.carry = operand[7];
                    end else begin
                        rot = {flags_q.carry, operand[7:1]};
                        flags_d.carry = operand[0];
                    end
                    if (op_q[9]) begin
                        file_d[op_q[6:0]] = rot;
                    end else begin
                        acc_d = rot;
                    end
                end else if (op_q == OPC_SLEEP) begin
                    wdog_d = WDOG_CLEAR;
                    presc_d = WDOG_CLEAR;
                    wclr_d = 1'b1;
                    flags_d.power_down_flag_n = 1'b0;
                    flags_d.watchdog_expiry_flag_n = 1'b1;
                    asleep_d = 1'b1;
                end else if (op_q[15:8] == OPC_LIT_SUB) begin
                    acc_d = diff[7:0];
                    flags_d.carry = (acc_q <= k_lit);
                    flags_d.half_carry_flag = (acc_q[3:0] <= k_lit[3:0]);
                    flags_d.zero = (diff[7:0] == 8'h00);
                end else begin
                    set_ill = 1'b1;
                end
            end
            EX_SECOND: begin
                state_d = EX_IDLE;
            end
            default: begin
                state_d = EX_IDLE;
            end
        endcase
        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid_in && awready_q) begin
            awaddr_d = s_axi_awaddr_in;
            aw_hold_d = 1'b1;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid_in && wready_q) begin
            wdata_d = s_axi_wdata_in;
            wstrb_d = s_axi_wstrb_in;
            w_hold_d = 1'b1;
            wready_d = 1'b0;
        end
        if (aw_hold_q && w_hold_q && !bvalid_q) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case (awaddr_q)
                OFF_INSTR: begin
                    // A new instruction is refused while one is still executing.
                    if (state_q == EX_IDLE && wstrb_q[1:0] == 2'b11) begin
                        op_d = wdata_q[15:0];
                        state_d = EX_RUN;
                        asleep_d = 1'b0;
                    end
                end
                OFF_STATUS: begin
                    if (wstrb_q[0]) begin
                        flags_d.carry = wdata_q[ST_C];
                        flags_d.half_carry_flag = wdata_q[ST_HCARRY];
                        flags_d.zero = wdata_q[ST_Z];
                        flags_d.power_down_flag_n = wdata_q[ST_PWRDN];
                        flags_d.watchdog_expiry_flag_n = wdata_q[ST_EXPIRY];
                        if (wdata_q[ST_ILL]) begin
                            illegal_d = 1'b0;
                        end
                    end
                end
                OFF_ACC: if (wstrb_q[0]) acc_d = wdata_q[7:0];
                OFF_PC: begin
                    if (wstrb_q[0]) pc_d[7:0] = wdata_q[7:0];
                    if (wstrb_q[1]) pc_d[14:8] = wdata_q[14:8];
                end
                OFF_PUSH: begin
                    if (wstrb_q[1:0] == 2'b11) begin
                        stack_d[sp_q] = wdata_q[14:0];
                        sp_d = sp_q + 4'h1;
                    end
                end
                OFF_FADDR: if (wstrb_q[0]) faddr_d = wdata_q[6:0];
                OFF_FDATA: if (wstrb_q[0]) file_d[faddr_q] = wdata_q[7:0];
                OFF_WDOG: begin
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        // Hardware setting the illegal flag wins over a software clear.
        if (set_ill) begin
            illegal_d = 1'b1;
        end
        if (s_axi_arvalid_in && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (s_axi_araddr_in)
                OFF_INSTR: rdata_d = {16'h0000, op_q};
                OFF_STATUS: rdata_d = status_rd;
                OFF_ACC: rdata_d = {24'h000000, acc_q};
                OFF_PC: rdata_d = {17'h00000, pc_q};
                OFF_PUSH: rdata_d = {17'h00000, top_entry};
                OFF_FADDR: rdata_d = {25'h0000000, faddr_q};
                OFF_FDATA: rdata_d = {24'h000000, file_q[faddr_q]};
                OFF_WDOG: rdata_d = {16'h0000, presc_q, wdog_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awaddr_q <= 8'h00;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            state_q <= EX_IDLE;
            op_q <= 16'h0000;
            acc_q <= ACC_RST;
            pc_q <= PC_RST;
            flags_q <= FLAGS_RST;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= PC_RST;
            end
            sp_q <= 4'h0;
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_q[i] <= 8'h00;
            end
            faddr_q <= 7'h00;
            wdog_q <= WDOG_CLEAR;
            presc_q <= WDOG_CLEAR;
            asleep_q <= 1'b0;
            illegal_q <= 1'b0;
            wclr_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awaddr_q <= awaddr_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            state_q <= state_d;
            op_q <= op_d;
            acc_q <= acc_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
            stack_q <= stack_d;
            sp_q <= sp_d;
            file_q <= file_d;
            faddr_q <= faddr_d;
            wdog_q <= wdog_d;
            presc_q <= presc_d;
            asleep_q <= asleep_d;
            illegal_q <= illegal_d;
            wclr_q <= wclr_d;
        end
    end

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;
    assign sleep_out = asleep_q;
    assign wdog_clear_out = wclr_q;

endmodule
`default_nettype wire

// ### testbench/rrs_exec_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module rrs_exec_asserts
    import rrs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Bus handshakes.
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Core side.
    input wire logic sleep_out,
    input wire logic wdog_clear_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence bad_wr;
        wr_taken ##0 (s_axi_awaddr_in >= 8'h20);
    endsequence
    a_clear_one_cycle: assert property (wdog_clear_out |=> !wdog_clear_out)
        else $error("watchdog clear held past one cycle");
    a_clear_in_write: assert property (
        wdog_clear_out |-> !s_axi_awready_out || !$past(s_axi_awready_out))
        else $error("watchdog clear outside an instruction write");
    a_sleep_after_clear: assert property (wdog_clear_out |-> ##[0:1] sleep_out)
        else $error("sleep did not follow watchdog clear");
    // Reset also ends sleep, and its release is seen before the sampled values settle.
    a_sleep_end_write: assert property (
        $fell(sleep_out) && !$past(reset_in) |-> !s_axi_wready_out || !$past(s_axi_wready_out))
        else $error("sleep ended without a write");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_out)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
        else $error("read response late");
    a_bad_addr_err: assert property (
        bad_wr |-> ##[1:2] s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_b_done: assert property (
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out)
        else $error("write response not closed");
    a_r_done: assert property (
        s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
        else $error("read response not closed");
    a_resp_readies_low: assert property (
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write readies high during response");
endmodule
bind rrs_exec rrs_exec_asserts u_rrs_exec_asserts (.clk_in, .reset_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .sleep_out, .wdog_clear_out);
`default_nettype wire

// ### testbench/rrs_exec_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rrs_exec_tb_top import rrs_pkg::*;;
    logic clk_in, reset_in, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic awready, wready, bvalid, arready, rvalid, sleep_o, wclr;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int error_cnt, n_checks, n_clr;
    // Each row: accumulator, register, opcode, expected accumulator, expected register,
    // then carry in, zero, half-carry and carry out in the low four bits.
    logic [55:0] rows [9] = '{56'h05_00_0805_00_00_07, 56'h11_00_0810_FF_00_08,
        56'h12_00_0834_22_00_03, 56'h01_00_0800_FF_00_08, 56'h00_00_08FF_FF_00_03,
        56'h3C_E6_3405_CD_E6_0F, 56'h3C_81_367F_3C_02_05, 56'h3C_01_3000_80_01_0F,
        56'h3C_02_3240_3C_01_04};
    rrs_exec u_rrs_exec (.clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .sleep_out(sleep_o), .wdog_clear_out(wclr));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (wclr === 1'b1) n_clr <= n_clr + 1;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Both channels are offered together; bready stays up until the answer is sampled.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ok;
        ok = 1'b0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            ok = (bvalid === 1'b1);
        end
        bready <= 1'b0;
        if (!ok) begin
            chk("write wait", 32'h1, 32'h0);
            print_verdict();
        end
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        bit ok;
        ok = 1'b0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            ok = (rvalid === 1'b1);
        end
        rready <= 1'b0;
        if (!ok) begin
            chk("read wait", 32'h1, 32'h0);
            print_verdict();
        end
        chk(nm, e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic ex(input logic [15:0] op);
        axw(OFF_INSTR, {16'h0, op}, RESP_OKAY);
        repeat (2) @(posedge clk_in);
    endtask
    initial begin
        logic [7:0] a, f, ea, ef, fl;
        logic [15:0] op;
        logic [31:0] es;
        int clr_base;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        reset_in = 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            {a, f, op, ea, ef, fl} = rows[i];
            axw(OFF_ACC, {24'h0, a}, RESP_OKAY);
            axw(OFF_FADDR, {25'h0, op[6:0]}, RESP_OKAY);
            axw(OFF_FDATA, {24'h0, f}, RESP_OKAY);
            axw(OFF_STATUS, {26'h0, 3'b111, fl[3], fl[3], 1'b0}, RESP_OKAY);
            es = {26'h0, 2'b11, fl[2:0], 1'b0};
            ex(op);
            rdc("acc", OFF_ACC, 32'hFFFF_FFFF, {24'h0, ea});
            rdc("file", OFF_FDATA, 32'hFF, {24'h0, ef});
            rdc("status", OFF_STATUS, 32'hFFFF_FFFF, es);
        end
        axw(OFF_PUSH, 32'h1234, RESP_OKAY);
        axw(OFF_PUSH, 32'h0456, RESP_OKAY);
        axw(OFF_STATUS, 32'h3A, RESP_OKAY);
        ex(16'h0CA5);
        rdc("acc", OFF_ACC, 32'hFF, 32'hA5);
        rdc("pc", OFF_PC, 32'h7FFF, 32'h0456);
        rdc("status", OFF_STATUS, 32'hFFF, 32'h13A);
        ex(16'h0012);
        rdc("pc", OFF_PC, 32'h7FFF, 32'h1234);
        ex(16'h0013);
        rdc("sp", OFF_STATUS, 32'hF00, 32'hF00);
        rdc("pc", OFF_PC, 32'h7FFF, 32'h0);
        ex(16'hFFFF);
        rdc("illegal", OFF_STATUS, 32'h80, 32'h80);
        // Long idle so the watchdog counter has left zero before sleep clears it.
        axw(OFF_STATUS, 32'h90, RESP_OKAY);
        repeat (300) @(posedge clk_in);
        clr_base = n_clr;
        ex(OPC_SLEEP);
        rdc("wdog", OFF_WDOG, 32'hE0FF, 32'h0);
        chk("clear pulses", 32'h1, n_clr - clr_base);
        rdc("status", OFF_STATUS, 32'hF0, 32'h60);
        chk("sleep", 32'h1, {31'h0, sleep_o});
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        chk("sleep reset", 32'h0, {31'h0, sleep_o});
        rdc("status rst", OFF_STATUS, 32'hFFFF_FFFF, 32'h30);
        rdc("acc rst", OFF_ACC, 32'hFFFF_FFFF, 32'h0);
        axw(8'h20, 32'h5A, RESP_SLVERR);
        rdc("unmapped", 8'h24, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        print_verdict();
    end
endmodule
`default_nettype wire
